/* File: rtl/servo_fault_consts.vh */
// Offsets, reset values, fault codes and timing constants of the fault monitor
`ifndef SERVO_FAULT_CONSTS_VH
`define SERVO_FAULT_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_OVERCURRENT_THR    8'h00
`define OFS_OVERLOAD_POINT     8'h04
`define OFS_STALL_CURRENT_THR  8'h08
`define OFS_STALL_TIME_THR     8'h0c
`define OFS_OVERSPEED_PCT      8'h10
`define OFS_FAULT_MASK         8'h14
`define OFS_RATED_VOLTAGE      8'h18
`define OFS_OVERHEAT_THR       8'h1c
`define OFS_POS_ERR_LIMIT      8'h20
`define OFS_SOFT_LIMIT_EN      8'h24
`define OFS_SOFT_LIMIT_LOW     8'h28
`define OFS_SOFT_LIMIT_HIGH    8'h2c
`define OFS_ZERO_DRIFT_THR     8'h30
`define OFS_HOMING_TIMEOUT     8'h34
`define OFS_CLASS2_STOP_MODE   8'h38
`define OFS_CLASS3_STOP_MODE   8'h3c
`define OFS_FAULT_CODE         8'h40
`define OFS_Q_CURRENT_FB       8'h44
`define OFS_DRIVE_CLASS        8'h48

// ----------------------------------------------------------------------------
// Reset values (percent and temperature in tenths)
// ----------------------------------------------------------------------------
`define RST_OVERCURRENT_THR    16'h0fa0
`define RST_OVERLOAD_POINT     16'h03e8
`define RST_STALL_CURRENT_THR  16'h03e8
`define RST_STALL_TIME_THR     16'h0320
`define RST_OVERSPEED_PCT      16'h05dc
`define RST_OVERHEAT_THR       16'h0320
`define RST_ZERO_DRIFT_THR     16'h01f4

// ----------------------------------------------------------------------------
// Fields and limits
// ----------------------------------------------------------------------------
`define MASK_BIT_SW_OVERCURRENT 1
`define OVERVOLT_220_DV        16'h1068
`define OVERVOLT_380_DV        16'h1d4c
`define UNDERVOLT_FACTOR       32'h000026aa
`define UNDERVOLT_SCALE        32'h000003e8
`define PCT_SCALE              32'h000003e8
`define STALL_SPEED_RPM        16'h0005
`define FN_HOME_SWITCH         8'h22
`define FN_FORWARD_TRAVEL      8'h2b
`define FN_REVERSE_TRAVEL      8'h2c
`define CAN_STATE_OPERATIONAL  8'h05
`define CLASS1_LOW             10'd100
`define CLASS1_HIGH            10'd199
`define CLASS2_LOW             10'd200
`define CLASS2_HIGH            10'd599
`define CLASS3_LOW             10'd600
`define CLASS3_HIGH            10'd999

// ----------------------------------------------------------------------------
// Fault codes
// ----------------------------------------------------------------------------
`define ER_SW_OVERCURRENT      10'd100
`define ER_OVERVOLTAGE         10'd102
`define ER_UNDERVOLTAGE        10'd103
`define ER_CURRENT_SENSOR      10'd104
`define ER_NV_VERIFY           10'd106
`define ER_CURRENT_STEP        10'd109
`define ER_DRIVE_OVERHEAT      10'd117
`define ER_NO_HOME_SWITCH      10'd200
`define ER_DUP_ASSIGN          10'd201
`define ER_OVERSPEED           10'd202
`define ER_POS_ERROR           10'd203
`define ER_SOFT_LIMIT          10'd207
`define ER_STALL               10'd219
`define ER_NO_FWD_TRAVEL       10'd221
`define ER_NO_REV_TRAVEL       10'd222
`define ER_BUS_STATE           10'd224
`define ER_ZERO_DRIFT          10'd602
`define ER_HOMING_TIMEOUT      10'd603

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS          10
`define MS_NS                  1000000
`define CYC_PER_MS             (`MS_NS / `CLK_PERIOD_NS)
`define MS_PER_S               1000

`endif

/* File: rtl/servo_fault_monitor.v */
// Fault supervision of a servo drive: threshold checks, fault latch, stop class
// ----------------------------------------------------------------------------
// How it works
// - Q current above threshold, unless mask bit1
// - Bus above 420V or 750V by class
// - Bus below rated times 1.414 times 0.7
// - Nonzero current at first relay close
// - Nonvolatile readback mismatch raises verify fault
// - Successive current samples differ fifty percent
// - Drive temperature above overheat threshold
// - One input function on several inputs
// - Speed percent above overspeed percentage
// - Position error above nonzero limit
// - Enabled soft limits, position outside range
// - Any analog zero drift above threshold
// - Homing time above timeout parameter
// - Current high, speed under 5 rpm, long
// - Homing start without home switch input
// - Travel switch functions must be assigned
// - State request while bus not operational
// - Class one codes cut power, coast
// - Class two codes use class two mode
// - Class three codes use class three mode
// ----------------------------------------------------------------------------
`include "servo_fault_consts.vh"

module servo_fault_monitor #(
  parameter N_DI       = 8,
  parameter CYC_PER_MS = `CYC_PER_MS
) (
  // Clock and reset
  input  wire               clk_i,
  input  wire               rst_i,
  // Register port
  input  wire [7:0]         addr_i,
  input  wire [31:0]        wr_data_i,
  input  wire               wr_i,
  input  wire               rd_i,
  output reg  [31:0]        rd_data_o,
  // Measurements
  input  wire signed [15:0] q_current_feedback_i,
  input  wire               current_sample_i,
  input  wire [15:0]        bus_voltage_i,
  input  wire [15:0]        drive_temperature_i,
  input  wire signed [15:0] speed_rpm_i,
  input  wire [15:0]        rated_speed_rpm_i,
  input  wire [31:0]        position_error_value_i,
  input  wire signed [31:0] encoder_position_i,
  input  wire [15:0]        analog_in1_drift_i,
  input  wire [15:0]        analog_in2_drift_i,
  input  wire [15:0]        analog_in3_drift_i,
  // Events
  input  wire               relay_close_i,
  input  wire               nv_check_i,
  input  wire [15:0]        nv_written_i,
  input  wire [15:0]        nv_read_i,
  input  wire               homing_active_i,
  input  wire [N_DI*8-1:0]  di_function_i,
  input  wire [7:0]         can_state_i,
  input  wire               state_change_req_i,
  // Fault outputs
  output reg  [9:0]         fault_code_o,
  output reg                fault_active_o,
  output reg                motor_power_cut_o,
  output reg  [2:0]         stop_mode_o
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [15:0] overcurrent_threshold;
  reg [15:0] overload_point;
  reg [15:0] stall_current_threshold;
  reg [15:0] stall_time_threshold;
  reg [15:0] overspeed_percentage;
  reg [15:0] fault_mask;
  reg [15:0] rated_voltage;
  reg [15:0] overheat_threshold;
  reg [31:0] position_error_limit;
  reg        soft_limit_enable;
  reg [31:0] soft_limit_low;
  reg [31:0] soft_limit_high;
  reg [15:0] zero_drift_threshold;
  reg [15:0] homing_timeout;
  reg [2:0]  class2_stop_mode;
  reg [2:0]  class3_stop_mode;
  reg        drive_class_380;
  reg [9:0]  fault_code;
  reg [31:0] next_rd_data;

  wire       clear_fault = wr_i && (addr_i == `OFS_FAULT_CODE);

  always @(posedge clk_i) begin
    if (rst_i) begin
      overcurrent_threshold   <= `RST_OVERCURRENT_THR;
      overload_point          <= `RST_OVERLOAD_POINT;
      stall_current_threshold <= `RST_STALL_CURRENT_THR;
      stall_time_threshold    <= `RST_STALL_TIME_THR;
      overspeed_percentage    <= `RST_OVERSPEED_PCT;
      fault_mask              <= 16'h0000;
      rated_voltage           <= 16'h0000;
      overheat_threshold      <= `RST_OVERHEAT_THR;
      position_error_limit    <= 32'h00000000;
      soft_limit_enable       <= 1'b0;
      soft_limit_low          <= 32'h00000000;
      soft_limit_high         <= 32'h00000000;
      zero_drift_threshold    <= `RST_ZERO_DRIFT_THR;
      homing_timeout          <= 16'h0000;
      class2_stop_mode        <= 3'h0;
      class3_stop_mode        <= 3'h0;
      drive_class_380         <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        `OFS_OVERCURRENT_THR:   overcurrent_threshold   <= wr_data_i[15:0];
        `OFS_OVERLOAD_POINT:    overload_point          <= wr_data_i[15:0];
        `OFS_STALL_CURRENT_THR: stall_current_threshold <= wr_data_i[15:0];
        `OFS_STALL_TIME_THR:    stall_time_threshold    <= wr_data_i[15:0];
        `OFS_OVERSPEED_PCT:     overspeed_percentage    <= wr_data_i[15:0];
        `OFS_FAULT_MASK:        fault_mask              <= wr_data_i[15:0];
        `OFS_RATED_VOLTAGE:     rated_voltage           <= wr_data_i[15:0];
        `OFS_OVERHEAT_THR:      overheat_threshold      <= wr_data_i[15:0];
        `OFS_POS_ERR_LIMIT:     position_error_limit    <= wr_data_i;
        `OFS_SOFT_LIMIT_EN:     soft_limit_enable       <= wr_data_i[0];
        `OFS_SOFT_LIMIT_LOW:    soft_limit_low          <= wr_data_i;
        `OFS_SOFT_LIMIT_HIGH:   soft_limit_high         <= wr_data_i;
        `OFS_ZERO_DRIFT_THR:    zero_drift_threshold    <= wr_data_i[15:0];
        `OFS_HOMING_TIMEOUT:    homing_timeout          <= wr_data_i[15:0];
        `OFS_CLASS2_STOP_MODE:  class2_stop_mode        <= wr_data_i[2:0];
        `OFS_CLASS3_STOP_MODE:  class3_stop_mode        <= wr_data_i[2:0];
        `OFS_DRIVE_CLASS:       drive_class_380         <= wr_data_i[0];
        default: ;
      endcase
    end
  end

  always @* begin
    case (addr_i)
      `OFS_OVERCURRENT_THR:   next_rd_data = {16'h0000, overcurrent_threshold};
      `OFS_OVERLOAD_POINT:    next_rd_data = {16'h0000, overload_point};
      `OFS_STALL_CURRENT_THR: next_rd_data = {16'h0000, stall_current_threshold};
      `OFS_STALL_TIME_THR:    next_rd_data = {16'h0000, stall_time_threshold};
      `OFS_OVERSPEED_PCT:     next_rd_data = {16'h0000, overspeed_percentage};
      `OFS_FAULT_MASK:        next_rd_data = {16'h0000, fault_mask};
      `OFS_RATED_VOLTAGE:     next_rd_data = {16'h0000, rated_voltage};
      `OFS_OVERHEAT_THR:      next_rd_data = {16'h0000, overheat_threshold};
      `OFS_POS_ERR_LIMIT:     next_rd_data = position_error_limit;
      `OFS_SOFT_LIMIT_EN:     next_rd_data = {31'h00000000, soft_limit_enable};
      `OFS_SOFT_LIMIT_LOW:    next_rd_data = soft_limit_low;
      `OFS_SOFT_LIMIT_HIGH:   next_rd_data = soft_limit_high;
      `OFS_ZERO_DRIFT_THR:    next_rd_data = {16'h0000, zero_drift_threshold};
      `OFS_HOMING_TIMEOUT:    next_rd_data = {16'h0000, homing_timeout};
      `OFS_CLASS2_STOP_MODE:  next_rd_data = {29'h00000000, class2_stop_mode};
      `OFS_CLASS3_STOP_MODE:  next_rd_data = {29'h00000000, class3_stop_mode};
      `OFS_FAULT_CODE:        next_rd_data = {22'h000000, fault_code};
      `OFS_Q_CURRENT_FB:      next_rd_data = {16'h0000, q_current_feedback_i};
      `OFS_DRIVE_CLASS:       next_rd_data = {31'h00000000, drive_class_380};
      default:                next_rd_data = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i)
      rd_data_o <= 32'h00000000;
    else if (rd_i)
      rd_data_o <= next_rd_data;
    else
      rd_data_o <= 32'h00000000;
  end

  // --------------------------------------------------------------------------
  // Magnitudes and scaled comparisons
  // --------------------------------------------------------------------------
  wire [15:0] cur_abs   = q_current_feedback_i[15] ? (~q_current_feedback_i + 16'h0001)
                                                    : q_current_feedback_i;
  wire [15:0] speed_abs = speed_rpm_i[15] ? (~speed_rpm_i + 16'h0001) : speed_rpm_i;
  wire [31:0] speed_scaled = {16'h0000, speed_abs} * `PCT_SCALE;
  wire [31:0] speed_limit  = {16'h0000, overspeed_percentage} * {16'h0000, rated_speed_rpm_i};
  wire [31:0] bus_scaled   = {16'h0000, bus_voltage_i} * `UNDERVOLT_SCALE;
  wire [31:0] bus_floor    = {16'h0000, rated_voltage} * `UNDERVOLT_FACTOR;
  wire [15:0] ov_limit     = drive_class_380 ? `OVERVOLT_380_DV : `OVERVOLT_220_DV;

  // --------------------------------------------------------------------------
  // Current step between samples
  // --------------------------------------------------------------------------
  reg  [15:0] prev_cur_abs;
  reg         prev_valid;
  wire [16:0] step = {1'b0, cur_abs} - {1'b0, prev_cur_abs};
  wire [15:0] step_abs = step[16] ? (~step[15:0] + 16'h0001) : step[15:0];
  wire        step_fault = current_sample_i && prev_valid && (step_abs != 16'h0000) &&
                           ({step_abs, 1'b0} >= {1'b0, prev_cur_abs});

  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_cur_abs <= 16'h0000;
      prev_valid   <= 1'b0;
    end else if (current_sample_i) begin
      prev_cur_abs <= cur_abs;
      prev_valid   <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Relay first closure
  // --------------------------------------------------------------------------
  reg relay_closed_once;
  always @(posedge clk_i) begin
    if (rst_i)
      relay_closed_once <= 1'b0;
    else if (relay_close_i)
      relay_closed_once <= 1'b1;
  end
  wire sensor_fault = relay_close_i && !relay_closed_once && (cur_abs != 16'h0000);

  // --------------------------------------------------------------------------
  // Millisecond and second ticks
  // --------------------------------------------------------------------------
  reg [31:0] ms_cnt;
  reg [15:0] ms_in_s;
  wire       ms_tick = (ms_cnt == CYC_PER_MS - 1);
  wire       s_tick  = ms_tick && (ms_in_s == `MS_PER_S - 1);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt  <= 32'h00000000;
      ms_in_s <= 16'h0000;
    end else begin
      ms_cnt <= ms_tick ? 32'h00000000 : ms_cnt + 32'h00000001;
      if (s_tick)
        ms_in_s <= 16'h0000;
      else if (ms_tick)
        ms_in_s <= ms_in_s + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Stall timing
  // --------------------------------------------------------------------------
  reg [15:0] stall_ms;
  wire stall_cond = (cur_abs > stall_current_threshold) && (speed_abs < `STALL_SPEED_RPM);
  always @(posedge clk_i) begin
    if (rst_i || !stall_cond)
      stall_ms <= 16'h0000;
    else if (ms_tick && stall_ms != 16'hffff)
      stall_ms <= stall_ms + 16'h0001;
  end
  wire stall_fault = stall_cond && (stall_ms >= stall_time_threshold);

  // --------------------------------------------------------------------------
  // Homing timing
  // --------------------------------------------------------------------------
  reg [15:0] homing_s;
  reg        homing_prev;
  always @(posedge clk_i) begin
    if (rst_i) begin
      homing_s    <= 16'h0000;
      homing_prev <= 1'b0;
    end else begin
      homing_prev <= homing_active_i;
      if (!homing_active_i)
        homing_s <= 16'h0000;
      else if (s_tick && homing_s != 16'hffff)
        homing_s <= homing_s + 16'h0001;
    end
  end
  wire homing_start   = homing_active_i && !homing_prev;
  wire homing_tmo     = homing_active_i && (homing_timeout != 16'h0000) &&
                        (homing_s > homing_timeout);

  // --------------------------------------------------------------------------
  // Input function assignment
  // --------------------------------------------------------------------------
  wire [N_DI-1:0] is_home;
  wire [N_DI-1:0] is_fwd;
  wire [N_DI-1:0] is_rev;
  wire [N_DI-1:0] dup;
  genvar i;
  generate
    for (i = 0; i < N_DI; i = i + 1) begin : g_di
      wire [7:0] fn = di_function_i[i*8 +: 8];
      reg        hit;
      integer    j;
      assign is_home[i] = (fn == `FN_HOME_SWITCH);
      assign is_fwd[i]  = (fn == `FN_FORWARD_TRAVEL);
      assign is_rev[i]  = (fn == `FN_REVERSE_TRAVEL);
      always @* begin
        hit = 1'b0;
        for (j = i + 1; j < N_DI; j = j + 1)
          if (fn != 8'h00 && fn == di_function_i[j*8 +: 8])
            hit = 1'b1;
      end
      assign dup[i] = hit;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Detection vector, ascending code order
  // --------------------------------------------------------------------------
  wire [17:0] det;
  assign det[0]  = (cur_abs > overcurrent_threshold) &&
                   !fault_mask[`MASK_BIT_SW_OVERCURRENT];
  assign det[1]  = bus_voltage_i > ov_limit;
  assign det[2]  = bus_scaled < bus_floor;
  assign det[3]  = sensor_fault;
  assign det[4]  = nv_check_i && (nv_written_i != nv_read_i);
  assign det[5]  = step_fault;
  assign det[6]  = drive_temperature_i > overheat_threshold;
  assign det[7]  = homing_start && (is_home == {N_DI{1'b0}});
  assign det[8]  = |dup;
  assign det[9]  = speed_scaled > speed_limit;
  assign det[10] = (position_error_limit != 32'h00000000) &&
                   (position_error_value_i > position_error_limit);
  assign det[11] = soft_limit_enable &&
                   ((encoder_position_i < $signed(soft_limit_low)) ||
                    (encoder_position_i > $signed(soft_limit_high)));
  assign det[12] = stall_fault;
  assign det[13] = (is_fwd == {N_DI{1'b0}});
  assign det[14] = (is_rev == {N_DI{1'b0}});
  assign det[15] = state_change_req_i && (can_state_i != `CAN_STATE_OPERATIONAL);
  assign det[16] = (analog_in1_drift_i > zero_drift_threshold) ||
                   (analog_in2_drift_i > zero_drift_threshold) ||
                   (analog_in3_drift_i > zero_drift_threshold);
  assign det[17] = homing_tmo;

  function [9:0] code_of;
    input [4:0] idx;
    begin
      case (idx)
        5'd0:    code_of = `ER_SW_OVERCURRENT;
        5'd1:    code_of = `ER_OVERVOLTAGE;
        5'd2:    code_of = `ER_UNDERVOLTAGE;
        5'd3:    code_of = `ER_CURRENT_SENSOR;
        5'd4:    code_of = `ER_NV_VERIFY;
        5'd5:    code_of = `ER_CURRENT_STEP;
        5'd6:    code_of = `ER_DRIVE_OVERHEAT;
        5'd7:    code_of = `ER_NO_HOME_SWITCH;
        5'd8:    code_of = `ER_DUP_ASSIGN;
        5'd9:    code_of = `ER_OVERSPEED;
        5'd10:   code_of = `ER_POS_ERROR;
        5'd11:   code_of = `ER_SOFT_LIMIT;
        5'd12:   code_of = `ER_STALL;
        5'd13:   code_of = `ER_NO_FWD_TRAVEL;
        5'd14:   code_of = `ER_NO_REV_TRAVEL;
        5'd15:   code_of = `ER_BUS_STATE;
        5'd16:   code_of = `ER_ZERO_DRIFT;
        default: code_of = `ER_HOMING_TIMEOUT;
      endcase
    end
  endfunction

  // Lowest code, the most severe, wins when several fire together
  reg [9:0] new_code;
  integer   k;
  always @* begin
    new_code = 10'd0;
    for (k = 17; k >= 0; k = k - 1)
      if (det[k])
        new_code = code_of(k[4:0]);
  end

  // --------------------------------------------------------------------------
  // Fault latch and stop class
  // --------------------------------------------------------------------------
  reg [9:0] next_code;
  reg       next_cut;
  reg [2:0] next_mode;
  always @* begin
    next_code = fault_code;
    if (clear_fault)
      next_code = 10'd0;
    // A detection in the clearing cycle still latches
    if (new_code != 10'd0 && (fault_code == 10'd0 || clear_fault))
      next_code = new_code;
    next_cut  = 1'b0;
    next_mode = 3'h0;
    if (next_code >= `CLASS1_LOW && next_code <= `CLASS1_HIGH) begin
      next_cut  = 1'b1;
      next_mode = 3'h0;
    end else if (next_code >= `CLASS2_LOW && next_code <= `CLASS2_HIGH) begin
      next_mode = class2_stop_mode;
    end else if (next_code >= `CLASS3_LOW && next_code <= `CLASS3_HIGH) begin
      next_mode = class3_stop_mode;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_code        <= 10'd0;
      fault_code_o      <= 10'd0;
      fault_active_o    <= 1'b0;
      motor_power_cut_o <= 1'b0;
      stop_mode_o       <= 3'h0;
    end else begin
      fault_code        <= next_code;
      fault_code_o      <= next_code;
      fault_active_o    <= (next_code != 10'd0);
      motor_power_cut_o <= next_cut;
      stop_mode_o       <= next_mode;
    end
  end

endmodule // servo_fault_monitor

/* File: verif/plant_model.sv */
// Sensor front end model: bus, current, temperature, speed and sample strobe
module plant_model (
  // Clock
  input  wire logic          clk_i,
  // Measurements
  output logic signed [15:0] q_o,
  output logic signed [15:0] speed_o,
  output logic [15:0]        bus_o,
  output logic [15:0]        temp_o,
  output logic               sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div = 2'h0;
  initial begin
    q_o = 16'sh0;
    speed_o = 16'sh3e8;
    bus_o = 16'hc80;
    temp_o = 16'h12c;
    sample_o = 1'b0;
  end
  // Current converter delivers a sample every fourth clock
  always @(posedge clk_i) begin
    div <= div + 2'h1;
    sample_o <= (div == 2'h3);
  end
endmodule // plant_model

/* File: verif/servo_fault_monitor_asserts.sv */
// Port checks of the fault monitor
module servo_fault_monitor_asserts #(
  parameter N_DI = 8
) (
  // Clock, reset and register port
  input wire logic              clk_i, rst_i, wr_i, rd_i,
  input wire logic [7:0]        addr_i,
  input wire logic [31:0]       rd_data_o,
  // Watched inputs
  input wire logic [15:0]       bus_voltage_i,
  input wire logic [N_DI*8-1:0] di_function_i,
  input wire logic [7:0]        can_state_i,
  input wire logic              state_change_req_i,
  // Fault outputs
  input wire logic [9:0]        fault_code_o,
  input wire logic              fault_active_o, motor_power_cut_o,
  input wire logic [2:0]        stop_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_idle; !fault_active_o; endsequence
  sequence s_code_read; rd_i && addr_i == 8'h40; endsequence
  chk_code_read: assert property (
    s_code_read |=> rd_data_o == {22'h0, $past(fault_code_o)}) else $error("code read differs");
  chk_code_hold: assert property (
    fault_active_o && !(wr_i && addr_i == 8'h40) |=> $stable(fault_code_o))
    else $error("latched code moved");
  chk_active_flag: assert property (fault_active_o == (fault_code_o != 10'h0))
    else $error("active flag disagrees with code");
  chk_class1_cut: assert property (
    motor_power_cut_o == (fault_code_o >= 10'h64 && fault_code_o <= 10'hc7))
    else $error("power cut disagrees with class");
  chk_class1_mode: assert property (fault_code_o < 10'hc8 |-> stop_mode_o == 3'h0)
    else $error("stop mode set outside classes two and three");
  chk_over_volt: assert property (s_idle ##0 bus_voltage_i > 16'h1d4c |=> fault_active_o)
    else $error("overvoltage not latched");
  chk_bus_state: assert property (
    s_idle ##0 (state_change_req_i && can_state_i != 8'h05) |=> fault_active_o)
    else $error("state request off bus not latched");
  chk_dup_assign: assert property (
    s_idle ##0 (di_function_i[7:0] != 8'h0 && di_function_i[7:0] == di_function_i[15:8])
    |=> fault_active_o) else $error("duplicate function not latched");
endmodule // servo_fault_monitor_asserts

/* File: verif/servo_fault_monitor_tb.sv */
// Self-checking bench: sensor model, register reads through a queue, fault scenarios
bind servo_fault_monitor servo_fault_monitor_asserts #(.N_DI(N_DI)) u_servo_fault_monitor_asserts (.*);
module servo_fault_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
  logic        homing_active_i = 1'b0, fault_active_o, motor_power_cut_o, sample;
  logic [2:0]  ev = 3'h0, stop_mode_o;
  logic [7:0]  addr_i = 8'h0, can_state_i = 8'h05, ofs[7] = '{0, 8'hc, 8'h10, 8'h1c, 8'h30, 8'h40, 8'h50};
  logic [31:0] wr_data_i = 32'h0, pos_err = 32'h0, enc = 32'h0, rnd = 32'h43ee, rd_data_o, exp_q[$];
  logic [31:0] val[7] = '{32'hfa0, 32'h320, 32'h5dc, 32'h320, 32'h1f4, 0, 0};
  logic [15:0] a2 = 16'h0, bus, temp;
  logic [63:0] di = 64'h2c2b22, dis[3] = '{64'h2c2222, 64'h2c0022, 64'h2b22};
  logic [9:0]  fault_code_o, codes[3] = '{10'hc9, 10'hdd, 10'hde};
  logic signed [15:0] q, speed;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  plant_model u_plant_model (.clk_i, .q_o(q), .speed_o(speed), .bus_o(bus), .temp_o(temp),
    .sample_o(sample));
  servo_fault_monitor #(.CYC_PER_MS(10)) u_servo_fault_monitor (.clk_i, .rst_i, .addr_i,
    .wr_data_i, .wr_i, .rd_i, .rd_data_o, .q_current_feedback_i(q), .current_sample_i(sample),
    .bus_voltage_i(bus), .drive_temperature_i(temp), .speed_rpm_i(speed),
    .rated_speed_rpm_i(16'hbb8), .position_error_value_i(pos_err), .encoder_position_i(enc),
    .analog_in1_drift_i(a2), .analog_in2_drift_i(a2), .analog_in3_drift_i(a2),
    .relay_close_i(ev[0]), .nv_check_i(ev[1]), .nv_written_i(16'h1234), .nv_read_i(16'h1235),
    .homing_active_i, .di_function_i(di), .can_state_i, .state_change_req_i(ev[2]),
    .fault_code_o, .fault_active_o, .motor_power_cut_o, .stop_mode_o);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Register access: write when w, else read expecting d
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= w;
    rd_i <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge clk_i);
    ev <= 3'h0;
  endtask
  task automatic chk(input logic [9:0] code);
    repeat (6) @(posedge clk_i);
    acc(8'h40, {22'h0, code}, 1'b0);
    acc(8'h40, 32'h0, 1'b1);
  endtask
  task automatic quiet();
    rnd = lfsr(rnd);
    u_plant_model.temp_o <= rnd[15:0] % 16'h320;
    u_plant_model.speed_o <= {7'h0, rnd[24:16]} + 16'sh64;
    repeat (6) @(posedge clk_i);
    acc(8'h40, 32'h0, 1'b1);
    chk(10'h0);
  endtask
  always @(posedge clk_i) begin
    rd_seen <= rd_i;
    cycles <= cycles + 1;
    if (rd_seen) cmp(rd_data_o, exp_q.pop_front());
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ofs[i]) acc(ofs[i], val[i], 1'b0);
    u_plant_model.bus_o <= 16'h1069;
    repeat (6) @(posedge clk_i);
    cmp(32'(motor_power_cut_o), 32'h1);
    u_plant_model.temp_o <= 16'h384;
    chk(10'h66);
    u_plant_model.bus_o <= 16'hc80;
    quiet();
    acc(8'h48, 32'h1, 1'b1);
    u_plant_model.bus_o <= 16'h1b58;
    quiet();
    u_plant_model.bus_o <= 16'h1d4d;
    chk(10'h66);
    u_plant_model.bus_o <= 16'hbb8;
    quiet();
    acc(8'h18, 32'h137, 1'b1);
    chk(10'h67);
    u_plant_model.bus_o <= 16'hc80;
    quiet();
    u_plant_model.temp_o <= 16'h321;
    chk(10'h75);
    quiet();
    acc(8'h14, 32'h2, 1'b1);
    u_plant_model.q_o <= 16'shfa1;
    chk(10'h6d);
    pulse(3'h1);
    chk(10'h68);
    acc(8'h14, 32'h0, 1'b1);
    chk(10'h64);
    u_plant_model.q_o <= 16'sh0;
    quiet();
    pulse(3'h2);
    chk(10'h6a);
    acc(8'h3c, 32'h3, 1'b1);
    a2 <= 16'h1f5;
    repeat (6) @(posedge clk_i);
    cmp(32'(stop_mode_o), 32'h3);
    chk(10'h25a);
    a2 <= 16'h0;
    quiet();
    acc(8'h38, 32'h2, 1'b1);
    acc(8'h20, 32'h64, 1'b1);
    pos_err <= 32'h65;
    repeat (6) @(posedge clk_i);
    cmp(32'(stop_mode_o), 32'h2);
    chk(10'hcb);
    pos_err <= 32'h0;
    quiet();
    acc(8'h28, 32'hfffffff6, 1'b1);
    acc(8'h2c, 32'ha, 1'b1);
    acc(8'h24, 32'h1, 1'b1);
    enc <= 32'hfffffff5;
    chk(10'hcf);
    enc <= 32'h0;
    quiet();
    foreach (dis[i]) begin
      di <= dis[i];
      chk(codes[i]);
      di <= 64'h2c2b22;
      quiet();
    end
    can_state_i <= 8'h0;
    pulse(3'h4);
    chk(10'he0);
    can_state_i <= 8'h05;
    pulse(3'h4);
    quiet();
    u_plant_model.speed_o <= 16'sh1195;
    chk(10'hca);
    quiet();
    acc(8'h0c, 32'h3, 1'b1);
    u_plant_model.speed_o <= 16'sh0;
    u_plant_model.q_o <= 16'sh5dc;
    chk(10'h6d);
    repeat (30) @(posedge clk_i);
    chk(10'hdb);
    u_plant_model.q_o <= 16'sh0;
    quiet();
    acc(8'h34, 32'h1, 1'b1);
    di <= 64'h2c2b00;
    homing_active_i <= 1'b1;
    chk(10'hc8);
    di <= 64'h2c2b22;
    quiet();
    repeat (20000) @(posedge clk_i);
    chk(10'h25b);
    homing_active_i <= 1'b0;
    quiet();
    finish_test();
  end
endmodule // servo_fault_monitor_tb
